// >>> acq_control_reg.sv
`timescale 1ns/1ps

// Function
// [RQ1] Six-bit control register: channel, convert, standby, format
// [RQ2] Parallel or serial writes, same field meaning
// [RQ3] Reset clears every register bit
// [RQ4] Host gives six clocks with frame low
// [RQ5] Early frame end leaves register unchanged
// [RQ6] Aborted frame with convert set restarts conversion
// [RQ7] Bit order: chan2..0, convert, standby, format
// [RQ8] Channel write starts settle pulse before hold; here a channel write starts the pulse only if its convert bit is set
// [RQ9] Selected input is address plus one
// [RQ10] Convert bit write starts pulse then conversion
// [RQ11] Held convert bit never repeats conversions
// [RQ12] Convert bit set masks hardware start input
// [RQ13] Standby bit selects power-down or normal
// [RQ14] Format bit: binary or two's complement
// [RQ15] Serial captures first six falling clock edges
// [RQ16] Parallel latches data on select and strobe
// [RQ17] Settle pulse lasts acquisition time
// [RQ18] Mode pin high parallel, low serial
// [RQ19] Fields change only after complete write
module acq_control_reg #(
  parameter int unsigned SETTLE_CYCLES = acq_ctrl_pkg::ACQ_CYCLES
) (
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_srst,
  input  wire logic                              i_ce,
  input  wire logic                              i_mode_parallel,
  input  wire logic                              i_chip_sel_n,
  input  wire logic                              i_write_n,
  input  wire logic [acq_ctrl_pkg::REG_WIDTH-1:0] i_data,
  input  wire logic                              i_sclk,
  input  wire logic                              i_write_frame_sync_n,
  input  wire logic                              i_serial_data_in,
  input  wire logic                              i_hw_convert_start_n,
  output logic      [acq_ctrl_pkg::REG_WIDTH-1:0] o_ctrl_reg,
  output logic      [3:0]                        o_input_select,
  output logic                                   o_standby,
  output logic                                   o_twos_complement,
  output logic                                   o_settle_pulse,
  output logic                                   o_hold,
  output logic                                   o_convert_start
);
  import acq_ctrl_pkg::*;

  localparam int unsigned NPIN = REG_WIDTH + 7;
  localparam int unsigned CW   = $clog2(SETTLE_CYCLES + 1);

  // Pin synchronisation: all pins come from outside this clock domain
  // Data lines share the strobe's synchroniser so both arrive with equal latency
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_lvl;
  assign pin_raw = {i_data, i_mode_parallel, i_chip_sel_n, i_write_n, i_sclk,
                    i_write_frame_sync_n, i_serial_data_in, i_hw_convert_start_n};

  acq_pin_sync #(.WIDTH(NPIN)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .i_async   (pin_raw),
    .i_rst_val ({NPIN{1'b1}}),
    .o_level   (pin_lvl)
  );

  // Synchronised pin levels
  logic [REG_WIDTH-1:0] data_lvl;
  logic                 mode_par;
  logic                 cs_n;
  logic                 wr_n;
  logic                 sclk;
  logic                 frame_n;
  logic                 sdin;
  logic                 hwcs_n;
  assign {data_lvl, mode_par, cs_n, wr_n, sclk, frame_n, sdin, hwcs_n} = pin_lvl;

  // One more stage on the data lines: a write takes the bus level from the cycle before the strobe edge is seen
  logic [REG_WIDTH-1:0] pdata_q;
  logic [REG_WIDTH-1:0] pdata_d;

  typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_DONE} ser_state_e;

  // Edge detection group
  logic                 sclk_q;
  logic                 sclk_d;
  logic                 frame_q;
  logic                 frame_d;
  logic                 wr_q;
  logic                 wr_d;
  logic                 hw_q;
  logic                 hw_d;
  logic                 sclk_fall;
  logic                 frame_fall;
  logic                 frame_rise;
  logic                 wr_rise;
  logic                 hw_rise;

  // Serial receive group
  ser_state_e           ser_q;
  ser_state_e           ser_d;
  logic [REG_WIDTH-1:0] shift_q;
  logic [REG_WIDTH-1:0] shift_d;
  logic [2:0]           bitcnt_q;
  logic [2:0]           bitcnt_d;
  logic                 write_done;
  logic                 start_pulse;
  logic [REG_WIDTH-1:0] new_val;

  // Register field group
  logic [REG_WIDTH-1:0] ctrl_q;
  logic [REG_WIDTH-1:0] ctrl_d;
  logic [3:0]           insel_q;
  logic [3:0]           insel_d;
  logic                 stby_q;
  logic                 stby_d;
  logic                 fmt_q;
  logic                 fmt_d;

  // Settle pulse and conversion group
  logic [CW-1:0]        settle_q;
  logic [CW-1:0]        settle_d;
  logic                 pulse_q;
  logic                 pulse_d;
  logic                 hold_q;
  logic                 hold_d;
  logic                 conv_q;
  logic                 conv_d;
  logic                 pulse_end;

  // Edges of the synchronised pin levels
  always_comb begin
    pdata_d    = data_lvl;
    sclk_d     = sclk;
    frame_d    = frame_n;
    wr_d       = wr_n;
    hw_d       = hwcs_n;
    sclk_fall  = sclk_q & ~sclk;
    frame_fall = frame_q & ~frame_n;
    frame_rise = ~frame_q & frame_n;
    wr_rise    = ~wr_q & wr_n & ~cs_n;
    hw_rise    = ~hw_q & hwcs_n;
  end

  // Serial receive state machine
  always_comb begin
    ser_d       = ser_q;
    shift_d     = shift_q;
    bitcnt_d    = bitcnt_q;
    write_done  = 1'b0;
    start_pulse = 1'b0;
    new_val     = ctrl_q;
    if (!mode_par) begin // [RQ18]
      case (ser_q)
        SER_IDLE: begin
          if (frame_fall) begin
            ser_d    = SER_SHIFT;
            bitcnt_d = 3'h0;
          end
        end
        SER_SHIFT: begin
          if (frame_rise) begin
            // Abort: register kept, a set convert bit still retriggers
            ser_d = SER_IDLE; // [RQ5]
            if (ctrl_q[CONVERT_POS]) begin
              start_pulse = 1'b1; // [RQ6]
            end
          end else if (sclk_fall) begin
            shift_d  = {shift_q[REG_WIDTH-2:0], sdin}; // [RQ15] [RQ7]
            bitcnt_d = bitcnt_q + 3'h1;
            if (bitcnt_q == 3'(REG_WIDTH - 1)) begin // [RQ4]
              ser_d      = SER_DONE;
              write_done = 1'b1;
              new_val    = {shift_q[REG_WIDTH-2:0], sdin};
            end
          end
        end
        SER_DONE: begin
          // Extra bits in the frame are ignored
          if (frame_rise) begin
            ser_d = SER_IDLE; // [RQ15]
          end
        end
        default: ser_d = SER_IDLE;
      endcase
    end else begin
      ser_d = SER_IDLE;
      if (wr_rise) begin
        write_done = 1'b1; // [RQ16]
        new_val    = pdata_q;
      end
    end
  end

  // Register fields: loaded only by a complete write
  always_comb begin
    ctrl_d  = ctrl_q;
    insel_d = insel_q;
    stby_d  = stby_q;
    fmt_d   = fmt_q;
    if (write_done) begin
      ctrl_d  = new_val; // [RQ2] [RQ19]
      insel_d = {1'b0, new_val[CHAN_MSB:CHAN_LSB]} + CHAN_BASE; // [RQ9]
      stby_d  = new_val[STANDBY_POS]; // [RQ13]
      fmt_d   = new_val[FORMAT_POS]; // [RQ14]
    end
  end

  // Settle pulse and conversion start
  always_comb begin
    settle_d  = settle_q;
    pulse_d   = pulse_q;
    hold_d    = hold_q;
    conv_d    = 1'b0;
    pulse_end = pulse_q && (settle_q == CW'(1));
    // A write with convert set, or an aborted frame while the stored bit is set, starts the pulse; the held bit alone never does
    // A start during a running pulse reloads it, giving one later conversion
    if ((write_done && new_val[CONVERT_POS]) || start_pulse) begin // [RQ8] [RQ10] [RQ11]
      pulse_d  = 1'b1;
      settle_d = CW'(SETTLE_CYCLES); // [RQ17]
      hold_d   = 1'b0;
    end else if (pulse_q) begin
      settle_d = settle_q - CW'(1);
      if (pulse_end) begin
        pulse_d = 1'b0;
        hold_d  = 1'b1; // [RQ8]
        conv_d  = 1'b1;
      end
    end else if (hw_rise && !ctrl_q[CONVERT_POS]) begin // [RQ12]
      hold_d = 1'b1;
      conv_d = 1'b1;
    end else begin
      hold_d = 1'b0;
    end
  end

  // Edge detectors preset to the idle-high level of their pins,
  // so releasing reset never shows a false edge
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pdata_q  <= CTRL_RESET;
      sclk_q   <= 1'b1;
      frame_q  <= 1'b1;
      wr_q     <= 1'b1;
      hw_q     <= 1'b1;
    end else if (i_ce) begin
      pdata_q  <= pdata_d;
      sclk_q   <= sclk_d;
      frame_q  <= frame_d;
      wr_q     <= wr_d;
      hw_q     <= hw_d;
    end
  end

  // Serial receiver
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ser_q    <= SER_IDLE;
      shift_q  <= CTRL_RESET;
      bitcnt_q <= 3'h0;
    end else if (i_ce) begin
      ser_q    <= ser_d;
      shift_q  <= shift_d;
      bitcnt_q <= bitcnt_d;
    end
  end

  // Register fields
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ctrl_q   <= CTRL_RESET; // [RQ3] [RQ1]
      insel_q  <= CHAN_BASE;
      stby_q   <= 1'b0;
      fmt_q    <= 1'b0;
    end else if (i_ce) begin
      ctrl_q   <= ctrl_d;
      insel_q  <= insel_d;
      stby_q   <= stby_d;
      fmt_q    <= fmt_d;
    end
  end

  // Settle pulse and conversion start
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      settle_q <= '0;
      pulse_q  <= 1'b0;
      hold_q   <= 1'b0;
      conv_q   <= 1'b0;
    end else if (i_ce) begin
      settle_q <= settle_d;
      pulse_q  <= pulse_d;
      hold_q   <= hold_d;
      conv_q   <= conv_d;
    end
  end

  assign o_ctrl_reg        = ctrl_q;
  assign o_input_select    = insel_q;
  assign o_standby         = stby_q;
  assign o_twos_complement = fmt_q;
  assign o_settle_pulse    = pulse_q;
  assign o_hold            = hold_q;
  assign o_convert_start   = conv_q;

endmodule // acq_control_reg

// >>> acq_ctrl_pkg.sv
package acq_ctrl_pkg;

  localparam int unsigned REG_WIDTH    = 6;
  localparam int unsigned CHAN_WIDTH   = 3;
  localparam int unsigned FORMAT_POS   = 0;
  localparam int unsigned STANDBY_POS  = 1;
  localparam int unsigned CONVERT_POS  = 2;
  localparam int unsigned CHAN_LSB     = 3;
  localparam int unsigned CHAN_MSB     = 5;
  localparam logic [5:0]  CTRL_RESET   = 6'h00;
  localparam logic [3:0]  CHAN_BASE    = 4'h1;

  // Clock rate and settle pulse (acquisition time)
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned ACQ_TIME_NS  = 600;
  localparam int unsigned ACQ_CYCLES   = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SYNC_STAGES  = 3;

endpackage : acq_ctrl_pkg

// >>> acq_pin_sync.sv
`timescale 1ns/1ps

// Three-stage synchroniser; a change is accepted once stages two and three agree.
module acq_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_srst,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_rst_val,
  output logic      [WIDTH-1:0] o_level
);
  import acq_ctrl_pkg::*;

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [WIDTH-1:0] s1_d, s2_d, s3_d, lvl_d;

  always_comb begin
    s1_d  = i_async;
    s2_d  = s1_q;
    s3_d  = s2_q;
    lvl_d = lvl_q;
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  // Reset presets the idle level so no false edge follows release
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s1_q  <= i_rst_val;
      s2_q  <= i_rst_val;
      s3_q  <= i_rst_val;
      lvl_q <= i_rst_val;
    end else if (i_ce) begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;

endmodule // acq_pin_sync

// >>> acq_ctrl_sva.sv
`timescale 1ns/1ps
module acq_ctrl_sva #(
  parameter int unsigned SETTLE_CYCLES = 60
) (
  input wire logic       i_ref_clk,
  input wire logic       i_srst,
  input wire logic [5:0] o_ctrl_reg,
  input wire logic [3:0] o_input_select,
  input wire logic       o_standby,
  input wire logic       o_twos_complement,
  input wire logic       o_settle_pulse,
  input wire logic       o_hold,
  input wire logic       o_convert_start
);
  int unsigned cnt_q;
  int unsigned cnt_d;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  // Cycles the settle pulse has been high
  always_comb cnt_d = o_settle_pulse ? cnt_q + 1 : 0;
  always_ff @(posedge i_ref_clk) cnt_q <= i_srst ? 0 : cnt_d;
  property p_sel; $stable(o_ctrl_reg)[*2] |-> o_input_select == {1'b0, o_ctrl_reg[5:3]} + 4'h1;
  endproperty
  a_sel: assert property (p_sel) else $error("input select wrong");
  property p_stby; $stable(o_ctrl_reg)[*2] |-> o_standby == o_ctrl_reg[1];
  endproperty
  a_stby: assert property (p_stby) else $error("standby wrong");
  property p_fmt; $stable(o_ctrl_reg)[*2] |-> o_twos_complement == o_ctrl_reg[0];
  endproperty
  a_fmt: assert property (p_fmt) else $error("format wrong");
  property p_hold; o_convert_start |-> o_hold && !o_settle_pulse;
  endproperty
  a_hold: assert property (p_hold) else $error("hold missing");
  property p_end; $fell(o_settle_pulse) |-> o_convert_start;
  endproperty
  a_end: assert property (p_end) else $error("no start after pulse");
  property p_len; $fell(o_settle_pulse) |-> cnt_q == SETTLE_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("pulse length wrong");
  property p_one; o_convert_start |=> !o_convert_start;
  endproperty
  a_one: assert property (p_one) else $error("start too long");
  property p_mask; o_convert_start && !$fell(o_settle_pulse) |-> !$past(o_ctrl_reg[2]);
  endproperty
  a_mask: assert property (p_mask) else $error("hw start not masked");
endmodule // acq_ctrl_sva

// >>> acq_host_model.sv
`timescale 1ns/1ps
module acq_host_model (
  input  wire logic i_ref_clk,
  output logic      o_cs_n,
  output logic      o_wr_n,
  output logic [5:0] o_data,
  output logic      o_sclk,
  output logic      o_fs_n,
  output logic      o_sdi,
  output logic      o_conv_n
);
  initial {o_cs_n, o_wr_n, o_data, o_sclk, o_fs_n, o_sdi, o_conv_n} = 12'hc0d;
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic par_write(input logic [5:0] v);
    o_cs_n <= 1'b0;
    o_data <= v;
    step(4);
    o_wr_n <= 1'b0;
    step(4);
    o_wr_n <= 1'b1;
    step(4);
    o_cs_n <= 1'b1;
    o_data <= ~v; // Released bus shows no stale value
    step(8);
  endtask
  // MSB first; n below six aborts the frame
  task automatic ser_write(input logic [7:0] v, input int n);
    o_fs_n <= 1'b0;
    for (int k = 7; k > 7 - n; k--) begin
      o_sdi <= v[k];
      step(4);
      o_sclk <= 1'b0;
      step(4);
      o_sclk <= 1'b1;
    end
    step(4);
    o_fs_n <= 1'b1;
    o_sdi <= ~o_sdi;
    step(8);
  endtask
  task automatic hw_start;
    o_conv_n <= 1'b0;
    step(4);
    o_conv_n <= 1'b1;
    step(8);
  endtask
endmodule // acq_host_model

// >>> tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb;
  import acq_ctrl_pkg::*;
  logic       i_ref_clk = 1'b0;
  logic       i_srst = 1'b1;
  logic       mode = 1'b1;
  logic       ce = 1'b1;
  logic       cs_n, wr_n, sclk, fs_n, sdi, conv_n;
  logic [5:0] data, ctrl;
  logic [3:0] sel;
  logic       stby, twos, pulse, hold, cst;
  int         error_cnt = 0;
  int         check_count = 0;
  int         n_conv = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (cst === 1'b1) n_conv++;
  acq_host_model host (.i_ref_clk(i_ref_clk), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_data(data),
    .o_sclk(sclk), .o_fs_n(fs_n), .o_sdi(sdi), .o_conv_n(conv_n));
  acq_control_reg #(.SETTLE_CYCLES(4)) dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .i_ce(ce), .i_mode_parallel(mode), .i_chip_sel_n(cs_n), .i_write_n(wr_n),
    .i_data(data), .i_sclk(sclk), .i_write_frame_sync_n(fs_n), .i_serial_data_in(sdi),
    .i_hw_convert_start_n(conv_n), .o_ctrl_reg(ctrl), .o_input_select(sel),
    .o_standby(stby), .o_twos_complement(twos), .o_settle_pulse(pulse), .o_hold(hold),
    .o_convert_start(cst));
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_reg(input logic [5:0] v);
    `CHK("ctrl", v, ctrl)
    `CHK("sel", {1'b0, v[5:3]} + 4'h1, sel)
    `CHK("stby", v[1], stby)
    `CHK("fmt", v[0], twos)
  endtask
  task automatic chk_conv(input int e);
    for (int k = 0; k < 40 && n_conv != e; k++) @(posedge i_ref_clk);
    `CHK("conv", e, n_conv)
  endtask
  initial begin
    host.step(2);
    i_srst <= 1'b0;
    host.step(5);
    chk_reg(6'h00);
    for (int c = 0; c < 8; c++) begin
      host.par_write({c[2:0], 3'b000});
      chk_reg({c[2:0], 3'b000});
    end
    host.par_write(6'h2b);
    chk_reg(6'h2b);
    chk_conv(0);
    host.ser_write(8'h14, 6);
    chk_reg(6'h2b);
    mode <= 1'b0;
    host.step(5);
    // Two extra bits in the frame must be dropped
    host.ser_write(8'h53, 8);
    chk_reg(6'h14);
    chk_conv(1);
    host.hw_start();
    host.step(40);
    chk_conv(1);
    host.ser_write(8'hff, 3);
    chk_reg(6'h14);
    chk_conv(2);
    host.ser_write(8'h44, 6);
    chk_reg(6'h11);
    host.hw_start();
    chk_conv(3);
    // Clock enable low freezes everything: a complete frame leaves no trace
    ce <= 1'b0;
    host.ser_write(8'hfc, 6);
    ce <= 1'b1;
    host.step(10);
    chk_reg(6'h11);
    chk_conv(3);
    i_srst <= 1'b1;
    host.step(2);
    i_srst <= 1'b0;
    host.step(5);
    chk_reg(6'h00);
    print_verdict();
  end
  initial begin
    #50us;
    error_cnt++;
    print_verdict();
  end
endmodule // tb
bind acq_control_reg acq_ctrl_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .o_ctrl_reg(o_ctrl_reg),
  .o_input_select(o_input_select), .o_standby(o_standby), .o_hold(o_hold),
  .o_twos_complement(o_twos_complement), .o_settle_pulse(o_settle_pulse),
  .o_convert_start(o_convert_start));
